// File: verilog/gpc_cfg.svh
// Purpose: Register offsets and reset values of the port pin block.
// Assumes: 4-bit register address, 8-bit register data.
// Notes: Definitions only.
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// ============================================================
// Register offsets
`define GPC_OFS_D_PINS 4'h0
`define GPC_OFS_D_LAT 4'h1
`define GPC_OFS_D_DIR 4'h2
`define GPC_OFS_D_ANS 4'h3
`define GPC_OFS_E_PINS 4'h4
`define GPC_OFS_E_LAT 4'h5
`define GPC_OFS_E_DIR 4'h6
`define GPC_OFS_E_ANS 4'h7
`define GPC_OFS_SLEW 4'h8

// ============================================================
// Field positions
`define GPC_E_CLR_BIT 3

// ============================================================
// Reset values
`define GPC_RST_D_LAT 2'h0
`define GPC_RST_D_DIR 2'h3
`define GPC_RST_D_ANS 2'h3
`define GPC_RST_E_LAT 3'h0
`define GPC_RST_E_DIR 3'h7
`define GPC_RST_E_ANS 3'h7
`define GPC_RST_SLEW 5'h1F

`endif

// File: verilog/gpc_pkg.sv
// Purpose: Types shared by the port pin block.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Offsets and values live in gpc_cfg.svh.
package gpc_pkg;

    // ============================================================
    // Types
    typedef logic [7:0] gpc_byte_type;

    // Which source drives an upper port D pin.
    typedef enum {
        GPC_SRC_SERIAL,
        GPC_SRC_PWM,
        GPC_SRC_LATCH,
        GPC_SRC_NONE
    } gpc_src_type;

endpackage : gpc_pkg

// File: verilog/gpc_port.sv
// Purpose: Port D pins 7:6 and port E pins 3:0 with their registers.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes: Pin outputs and read data are registered, one cycle behind.
// Notes on behaviour
// - Port E is four bits; pins 2:0 each have own direction.
// - Direction 1 turns driver off unless serial owns the pin; 0 drives the latch bit unless PWM or serial owns it.
// - An analog-selected pin reads as 0 in the pin register.
// - The latch register reads back latch contents, not pin levels.
// - After reset port E pins 2:0 are analog inputs.
// - Port E pin 3 is input only; clear enable picks clear function.
// - After reset pin 3 reads digitally only with clear disabled.
// - Pin 6 drives its latch with direction 0 when no PWM or serial owns it, even when analog.
// - Digital input off while analog; on with direction 1, analog 0.
// - Pin 7 carries PWM output d with direction 0.
// - Pin 6 carries PWM output c with direction 0.
// - Serial unit drives its clock on pin 6 even with direction 1.
// - Serial receive data comes from pin 7 with direction 1.
// - Unimplemented register bits read as 0.
// - The highest priority output function owns the pin driver.
`include "gpc_cfg.svh"

module gpc_port
    import gpc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [7:6] i_port_d_pin,
    output logic [7:6] o_port_d_pin_out,
    output logic [7:6] o_port_d_pin_oe,
    input wire logic [2:0] i_port_e_pin,
    output logic [2:0] o_port_e_pin_out,
    output logic [2:0] o_port_e_pin_oe,
    input wire logic i_port_e_pin3_input,
    input wire logic i_clear_pin_enable_cfg,
    output logic o_master_clear_req,
    input wire logic i_pwm1_output_c,
    input wire logic i_pwm1_c_en,
    input wire logic i_pwm1_output_d,
    input wire logic i_pwm1_d_en,
    input wire logic i_serial2_tx,
    input wire logic i_serial2_tx_en,
    input wire logic i_serial2_sync_clock,
    input wire logic i_serial2_clock_en,
    input wire logic i_serial2_sync_data,
    input wire logic i_serial2_data_en,
    output logic o_serial2_rx,
    output logic o_serial2_clock_in,
    output logic [4:0] o_slew_rate_control
);

    // ============================================================
    // Declarations
    logic [7:6] d_s1_q, d_s2_q;
    logic [3:0] e_s1_q, e_s2_q;
    logic cfg_s1_q, cfg_s2_q;
    logic [7:6] lat_d_q, dir_d_q, ans_d_q;
    logic [2:0] lat_e_q, dir_e_q, ans_e_q;
    logic [4:0] slew_q;
    gpc_byte_type rdata_q;
    logic [7:6] d_out_q, d_oe_q;
    logic [2:0] e_out_q, e_oe_q;
    logic clr_q, rx_q, ckin_q;

    // ============================================================
    // Pin synchronisers
    // Every pin passes two flops before any logic reads it.
    always_ff @(posedge i_clk) begin
        d_s1_q <= i_port_d_pin;
        d_s2_q <= d_s1_q;
        e_s1_q <= {i_port_e_pin3_input, i_port_e_pin};
        e_s2_q <= e_s1_q;
        cfg_s1_q <= i_clear_pin_enable_cfg;
        cfg_s2_q <= cfg_s1_q;
    end

    // ============================================================
    // Address decode
    // Writes to a pin register land in the matching latch.
    wire wr_d_lat = i_wr && (i_addr == `GPC_OFS_D_LAT ||
                             i_addr == `GPC_OFS_D_PINS);
    wire wr_d_dir = i_wr && i_addr == `GPC_OFS_D_DIR;
    wire wr_d_ans = i_wr && i_addr == `GPC_OFS_D_ANS;
    wire wr_e_lat = i_wr && (i_addr == `GPC_OFS_E_LAT ||
                             i_addr == `GPC_OFS_E_PINS);
    wire wr_e_dir = i_wr && i_addr == `GPC_OFS_E_DIR;
    wire wr_e_ans = i_wr && i_addr == `GPC_OFS_E_ANS;
    wire wr_slew = i_wr && i_addr == `GPC_OFS_SLEW;

    // ============================================================
    // Control registers
    // Port E comes up analog with drivers off.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            lat_d_q <= `GPC_RST_D_LAT;
            dir_d_q <= `GPC_RST_D_DIR;
            ans_d_q <= `GPC_RST_D_ANS;
            lat_e_q <= `GPC_RST_E_LAT;
            dir_e_q <= `GPC_RST_E_DIR;
            ans_e_q <= `GPC_RST_E_ANS;
            slew_q <= `GPC_RST_SLEW;
        end else begin
            if (wr_d_lat) lat_d_q <= i_wdata[7:6];
            if (wr_d_dir) dir_d_q <= i_wdata[7:6];
            if (wr_d_ans) ans_d_q <= i_wdata[7:6];
            if (wr_e_lat) lat_e_q <= i_wdata[2:0];
            if (wr_e_dir) dir_e_q <= i_wdata[2:0];
            if (wr_e_ans) ans_e_q <= i_wdata[2:0];
            if (wr_slew) slew_q <= i_wdata[4:0];
        end
    end

    // ============================================================
    // Pin level views
    // Analog pins read 0; pin 3 reads only when clear is disabled.
    wire [7:6] d_dig = d_s2_q & ~ans_d_q;
    wire [2:0] e_dig = e_s2_q[2:0] & ~ans_e_q;
    wire e3_dig = e_s2_q[`GPC_E_CLR_BIT] & ~cfg_s2_q;

    // ============================================================
    // Read multiplexer
    // Unused bit positions and unmapped offsets return zero.
    gpc_byte_type rd_mux;
    always_comb begin
        case (i_addr)
            `GPC_OFS_D_PINS: rd_mux = {d_dig, 6'h00};
            `GPC_OFS_D_LAT: rd_mux = {lat_d_q, 6'h00};
            `GPC_OFS_D_DIR: rd_mux = {dir_d_q, 6'h00};
            `GPC_OFS_D_ANS: rd_mux = {ans_d_q, 6'h00};
            `GPC_OFS_E_PINS: rd_mux = {4'h0, e3_dig, e_dig};
            `GPC_OFS_E_LAT: rd_mux = {5'h00, lat_e_q};
            `GPC_OFS_E_DIR: rd_mux = {5'h00, dir_e_q};
            `GPC_OFS_E_ANS: rd_mux = {5'h00, ans_e_q};
            `GPC_OFS_SLEW: rd_mux = {3'h0, slew_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= i_rd ? rd_mux : 8'h00;
        end
    end

    // ============================================================
    // Upper port D source selection
    // Serial outputs outrank PWM, which outranks the latch.
    // Analog select never blocks an output function.
    wire [7:6] pwm_en = {i_pwm1_d_en, i_pwm1_c_en};
    wire [7:6] pwm_val = {i_pwm1_output_d, i_pwm1_output_c};
    wire [7:6] ser_en = {i_serial2_data_en,
                         i_serial2_tx_en | i_serial2_clock_en};
    wire ser6_val = i_serial2_clock_en ? i_serial2_sync_clock
                                       : i_serial2_tx;
    wire [7:6] ser_val = {i_serial2_sync_data, ser6_val};
    wire [7:6] d_out_d;
    wire [7:6] d_oe_d;

    generate
        for (genvar p = 6; p <= 7; p++) begin : g_dpin
            gpc_src_type src;
            logic out_d;
            logic oe_d;
            // Pick the owner of the pin driver.
            assign src = ser_en[p] ? GPC_SRC_SERIAL :
                         !dir_d_q[p] && pwm_en[p] ? GPC_SRC_PWM :
                         !dir_d_q[p] ? GPC_SRC_LATCH : GPC_SRC_NONE;
            always_comb begin
                case (src)
                    GPC_SRC_SERIAL: begin
                        out_d = ser_val[p];
                        oe_d = 1'b1;
                    end
                    GPC_SRC_PWM: begin
                        out_d = pwm_val[p];
                        oe_d = 1'b1;
                    end
                    GPC_SRC_LATCH: begin
                        out_d = lat_d_q[p];
                        oe_d = 1'b1;
                    end
                    default: begin
                        out_d = 1'b0;
                        oe_d = 1'b0;
                    end
                endcase
            end
            // Each bit of the next pin state has one driver of its own.
            assign d_out_d[p] = out_d;
            assign d_oe_d[p] = oe_d;
        end
    endgenerate

    // ============================================================
    // Pin drivers and peripheral inputs
    // Port E drives its latch wherever direction is 0.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            d_out_q <= 2'h0;
            d_oe_q <= 2'h0;
            e_out_q <= 3'h0;
            e_oe_q <= 3'h0;
            clr_q <= 1'b0;
            rx_q <= 1'b1;
            ckin_q <= 1'b1;
        end else begin
            d_out_q <= d_out_d;
            d_oe_q <= d_oe_d;
            e_out_q <= lat_e_q & ~dir_e_q;
            e_oe_q <= ~dir_e_q;
            clr_q <= cfg_s2_q & ~e_s2_q[`GPC_E_CLR_BIT];
            rx_q <= dir_d_q[7] && !ans_d_q[7] ? d_s2_q[7] : 1'b1;
            ckin_q <= dir_d_q[6] && !ans_d_q[6] ? d_s2_q[6] : 1'b1;
        end
    end

    assign o_rdata = rdata_q;
    assign o_port_d_pin_out = d_out_q;
    assign o_port_d_pin_oe = d_oe_q;
    assign o_port_e_pin_out = e_out_q;
    assign o_port_e_pin_oe = e_oe_q;
    assign o_master_clear_req = clr_q;
    assign o_serial2_rx = rx_q;
    assign o_serial2_clock_in = ckin_q;
    assign o_slew_rate_control = slew_q;

    // ============================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    dir_drive_a: assert property (
        i_wr && i_addr == `GPC_OFS_E_DIR |=> ##1
        o_port_e_pin_oe == ~$past(i_wdata[2:0], 2))
        else $error("port E driver enable does not follow direction");

    analog_zero_a: assert property (
        i_rd && i_addr == `GPC_OFS_E_PINS |=>
        (o_rdata[2:0] & $past(ans_e_q)) == 3'h0)
        else $error("analog pin read back non-zero");

    latch_back_a: assert property (
        i_wr && i_addr == `GPC_OFS_E_LAT ##1
        i_rd && i_addr == `GPC_OFS_E_LAT |=>
        o_rdata == {5'h00, $past(i_wdata[2:0], 2)})
        else $error("latch read differs from value written");

    por_analog_a: assert property (
        !$past(i_nrst) |-> ans_e_q == 3'h7 && dir_e_q == 3'h7)
        else $error("port E not analog input after reset");

    clear_pin_a: assert property (
        cfg_s2_q && !e_s2_q[3] |=> o_master_clear_req)
        else $error("master clear not raised");

    pin3_read_a: assert property (
        i_rd && i_addr == `GPC_OFS_E_PINS && cfg_s2_q |=> !o_rdata[3])
        else $error("pin 3 read while acting as clear");

    latch_pin6_a: assert property (
        !dir_d_q[6] && !ser_en[6] && !pwm_en[6] |=>
        o_port_d_pin_oe[6] && o_port_d_pin_out[6] == $past(lat_d_q[6]))
        else $error("pin 6 not driving its latch");

    pwm_pin7_a: assert property (
        !dir_d_q[7] && !ser_en[7] && pwm_en[7] |=>
        o_port_d_pin_out[7] == $past(i_pwm1_output_d))
        else $error("pin 7 not carrying PWM output");

    ser_clock_a: assert property (
        i_serial2_clock_en |=> o_port_d_pin_oe[6] &&
        o_port_d_pin_out[6] == $past(i_serial2_sync_clock))
        else $error("serial clock not driven on pin 6");

    rx_path_a: assert property (
        dir_d_q[7] && !ans_d_q[7] |=> o_serial2_rx == $past(d_s2_q[7]))
        else $error("serial receive not taken from pin 7");

    unimpl_zero_a: assert property (
        i_rd && i_addr == `GPC_OFS_E_LAT |=> o_rdata[7:3] == 5'h00)
        else $error("unimplemented bits read non-zero");

    pwm_pin6_a: assert property (
        !dir_d_q[6] && !ser_en[6] && pwm_en[6] |=>
        o_port_d_pin_oe[6] && o_port_d_pin_out[6] == $past(i_pwm1_output_c))
        else $error("pin 6 not carrying PWM output");

    ser_data_a: assert property (
        ser_en[7] |=> o_port_d_pin_oe[7] &&
        o_port_d_pin_out[7] == $past(i_serial2_sync_data))
        else $error("serial data does not own pin 7");

    dig_off_a: assert property (
        i_rd && i_addr == `GPC_OFS_D_PINS |=>
        (o_rdata[7:6] & $past(ans_d_q)) == 2'h0)
        else $error("analog port D pin read back non-zero");

    pin3_level_a: assert property (
        i_rd && i_addr == `GPC_OFS_E_PINS && !cfg_s2_q |=>
        o_rdata[3] == $past(e_s2_q[3]))
        else $error("pin 3 read differs from its synchronised level");

endmodule // gpc_port

// File: dv/gpc_board.sv
// Purpose: Board model that resolves the port pins of the block.
// Assumes: No pull resistors; the board drives undriven pins.
// Notes: Resolved levels feed the block's pin inputs.
module gpc_board (
    input wire logic [7:6] i_d_out,
    input wire logic [7:6] i_d_oe,
    input wire logic [2:0] i_e_out,
    input wire logic [2:0] i_e_oe,
    input wire logic [7:6] i_d_ext,
    input wire logic [2:0] i_e_ext,
    output logic [7:6] o_d_lvl,
    output logic [2:0] o_e_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Pin resolution
    // A pin follows the block while it drives, else the board.
    assign o_d_lvl = (i_d_oe & i_d_out) | (~i_d_oe & i_d_ext);
    assign o_e_lvl = (i_e_oe & i_e_out) | (~i_e_oe & i_e_ext);
endmodule // gpc_board

// File: dv/tb.sv
// Purpose: Self-checking bench for the port pin block.
// Assumes: Port D register bits sit at 7:6.
// Notes: Strobes, address and write data change by non-blocking assignment at rising edges; other inputs change 1 ns after an edge.
`include "gpc_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
    miscompares++; $display("CHECK FAILED t=%0t got %h exp %h", \
    $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpc_pkg::*;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata;
    logic [7:6] i_port_d_pin, o_port_d_pin_out, o_port_d_pin_oe;
    logic [7:6] d_ext = 2'h0;
    logic [2:0] i_port_e_pin, o_port_e_pin_out, o_port_e_pin_oe;
    logic [2:0] e_ext = 3'h0;
    logic i_port_e_pin3_input = 1'b1, i_clear_pin_enable_cfg = 1'b1;
    logic i_pwm1_output_c = 1'b0, i_pwm1_c_en = 1'b0;
    logic i_pwm1_output_d = 1'b0, i_pwm1_d_en = 1'b0;
    logic i_serial2_tx = 1'b0, i_serial2_tx_en = 1'b0;
    logic i_serial2_sync_clock = 1'b0, i_serial2_clock_en = 1'b0;
    logic i_serial2_sync_data = 1'b0, i_serial2_data_en = 1'b0;
    logic o_master_clear_req, o_serial2_rx, o_serial2_clock_in;
    logic [4:0] o_slew_rate_control;
    int miscompares = 0, compares = 0;
    // ============================================================
    // Instances
    gpc_port gpc_port_inst (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_port_d_pin, .o_port_d_pin_out,
        .o_port_d_pin_oe, .i_port_e_pin, .o_port_e_pin_out,
        .o_port_e_pin_oe, .i_port_e_pin3_input, .i_clear_pin_enable_cfg,
        .o_master_clear_req, .i_pwm1_output_c, .i_pwm1_c_en,
        .i_pwm1_output_d, .i_pwm1_d_en, .i_serial2_tx, .i_serial2_tx_en,
        .i_serial2_sync_clock, .i_serial2_clock_en, .i_serial2_sync_data,
        .i_serial2_data_en, .o_serial2_rx, .o_serial2_clock_in,
        .o_slew_rate_control);
    gpc_board gpc_board_inst (.i_d_out(o_port_d_pin_out),
        .i_d_oe(o_port_d_pin_oe), .i_e_out(o_port_e_pin_out),
        .i_e_oe(o_port_e_pin_oe), .i_d_ext(d_ext), .i_e_ext(e_ext),
        .o_d_lvl(i_port_d_pin), .o_e_lvl(i_port_e_pin));
    // ============================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask
    // Write then read back with no gap between the two strobes.
    task automatic wr_rd_chk(input logic [3:0] a, input logic [7:0] d,
                             input logic [7:0] e);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask
    task automatic finish_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_reset();
        rd_chk(`GPC_OFS_D_LAT, 8'h00);
        rd_chk(`GPC_OFS_D_DIR, 8'hC0);
        rd_chk(`GPC_OFS_E_DIR, 8'h07);
        rd_chk(`GPC_OFS_E_ANS, 8'h07);
        rd_chk(`GPC_OFS_E_PINS, 8'h00);
        rd_chk(`GPC_OFS_SLEW, 8'h1F);
        rd_chk(4'hF, 8'h00);
        `CHK(o_port_e_pin_oe, 3'h0)
        wr(`GPC_OFS_SLEW, 8'hE0);
        rd_chk(`GPC_OFS_SLEW, 8'h00);
        `CHK(o_slew_rate_control, 5'h00)
        $display("test reset done");
    endtask
    task automatic t_port_e();
        wr_rd_chk(`GPC_OFS_E_LAT, 8'hFF, 8'h07);
        wr(`GPC_OFS_E_ANS, 8'h00);
        wr(`GPC_OFS_E_DIR, 8'h02);
        tick(3);
        `CHK(o_port_e_pin_oe, 3'h5)
        `CHK(o_port_e_pin_out, 3'h5)
        rd_chk(`GPC_OFS_E_PINS, 8'h05);
        rd_chk(`GPC_OFS_E_LAT, 8'h07);
        wr(`GPC_OFS_E_PINS, 8'h00);
        rd_chk(`GPC_OFS_E_LAT, 8'h00);
        `CHK(o_port_e_pin_out, 3'h0)
        e_ext <= 3'h7;
        wr(`GPC_OFS_E_DIR, 8'h07);
        wr(`GPC_OFS_E_ANS, 8'h05);
        tick(3);
        rd_chk(`GPC_OFS_E_PINS, 8'h02);
        $display("test port_e done");
    endtask
    task automatic t_clear();
        i_clear_pin_enable_cfg <= 1'b0;
        i_port_e_pin3_input <= 1'b0;
        tick(4);
        `CHK(o_master_clear_req, 1'b0)
        i_port_e_pin3_input <= 1'b1;
        tick(3);
        rd_chk(`GPC_OFS_E_PINS, 8'h0A);
        i_clear_pin_enable_cfg <= 1'b1;
        i_port_e_pin3_input <= 1'b0;
        for (int k = 0; k < 5 && o_master_clear_req !== 1'b1; k++) tick(1);
        `CHK(o_master_clear_req, 1'b1)
        rd_chk(`GPC_OFS_E_PINS, 8'h02);
        i_port_e_pin3_input <= 1'b1;
        tick(4);
        `CHK(o_master_clear_req, 1'b0)
        $display("test clear done");
    endtask
    task automatic t_port_d();
        wr(`GPC_OFS_D_LAT, 8'hFF);
        rd_chk(`GPC_OFS_D_LAT, 8'hC0);
        wr(`GPC_OFS_D_DIR, 8'h00);
        tick(2);
        `CHK({o_port_d_pin_oe, o_port_d_pin_out}, 4'hF)
        i_pwm1_c_en <= 1'b1;
        i_pwm1_d_en <= 1'b1;
        i_pwm1_output_d <= 1'b1;
        wr(`GPC_OFS_D_LAT, 8'h00);
        tick(2);
        `CHK(o_port_d_pin_out, 2'h2)
        i_pwm1_output_c <= 1'b1;
        i_pwm1_output_d <= 1'b0;
        tick(2);
        `CHK(o_port_d_pin_out, 2'h1)
        i_serial2_tx_en <= 1'b1;
        tick(2);
        `CHK({o_port_d_pin_oe, o_port_d_pin_out}, 4'hC)
        wr(`GPC_OFS_D_DIR, 8'hC0);
        tick(2);
        `CHK({o_port_d_pin_oe, o_port_d_pin_out}, 4'h4)
        i_serial2_clock_en <= 1'b1;
        i_serial2_sync_clock <= 1'b1;
        i_serial2_data_en <= 1'b1;
        tick(2);
        `CHK({o_port_d_pin_oe, o_port_d_pin_out}, 4'hD)
        {i_serial2_tx_en, i_serial2_clock_en, i_serial2_data_en} <= 3'h0;
        d_ext <= 2'h1;
        wr(`GPC_OFS_D_ANS, 8'h00);
        tick(3);
        `CHK({o_serial2_rx, o_serial2_clock_in}, 2'h1)
        rd_chk(`GPC_OFS_D_PINS, 8'h40);
        d_ext <= 2'h3;
        wr(`GPC_OFS_D_ANS, 8'h40);
        tick(3);
        rd_chk(`GPC_OFS_D_PINS, 8'h80);
        $display("test port_d done");
    endtask
    // ============================================================
    // Clock, watchdog and main sequence
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        #50000;
        miscompares++;
        finish_test();
    end
    initial begin
        tick(2);
        i_nrst <= 1'b1;
        t_reset();
        t_port_e();
        t_clear();
        t_port_d();
        finish_test();
    end
endmodule // tb
